// >>> aefl_map.vh
// aefl_map.vh: register offsets, flag positions, reset values and timing
// constants of the actuator error-flag block; definitions only.
`ifndef AEFL_MAP_VH
`define AEFL_MAP_VH

// register byte offsets
`define AEFL_OFS_ERR      8'h00
`define AEFL_OFS_IRQ_STS  8'h04
`define AEFL_OFS_IRQ_MSK  8'h08
`define AEFL_OFS_TMO_MS   8'h0C
`define AEFL_OFS_MOTION   8'h10

// error flag bit positions
`define AEFL_BIT_PARAM    0
`define AEFL_BIT_OVL      1
`define AEFL_BIT_VOLT     2
`define AEFL_BIT_TEMP     3
`define AEFL_BIT_BKDRV    4
`define AEFL_BIT_TMO      5
`define AEFL_BIT_FATAL    6
`define AEFL_NUM_EVT      7

// reset values
`define AEFL_RST_FLAGS    7'h00
`define AEFL_RST_MSK      7'h00
`define AEFL_RST_TMO_MS   16'h1388
`define AEFL_RST_CUR_LIM  16'h0000
`define AEFL_RST_CNT      32'h00000000
`define AEFL_RST_RDATA    32'h00000000

// largest command values accepted for this actuator model
`define AEFL_MAX_CUR_LIM  16'h00FF
`define AEFL_MAX_SPEED    8'h64

// timing: clock rate and documented times in their own units
`define AEFL_CLK_HZ       64'd250000000
`define AEFL_MS_PER_S     64'd1000
`define AEFL_OVL_MS       64'd8
`define AEFL_GRACE_S      64'd10

`endif

// >>> aefl_cnt.v
// aefl_cnt.v: saturating 32-bit event counter with clear and step.
// assumes clear and step are synchronous to clk_in; done is a level.
`timescale 1ns/10ps
module aefl_cnt (
  input  wire        clk_in,    // block clock
  input  wire        rst_in,    // synchronous reset, high
  input  wire        ce_in,     // clock enable, freezes state when low
  input  wire        clr_in,    // restart the count
  input  wire        step_in,   // count one
  input  wire [31:0] limit_in,  // count that raises done
  output wire        done_out   // count has reached limit
);
`include "aefl_map.vh"

  reg [31:0] cnt_ff;

  assign done_out = (cnt_ff >= limit_in);

  // count up to the limit, then hold so done stays up without wrapping
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt_ff <= `AEFL_RST_CNT;
    end else if (ce_in) begin
      if (clr_in) begin
        cnt_ff <= `AEFL_RST_CNT;
      end else if (step_in && !done_out) begin
        cnt_ff <= cnt_ff + 32'h00000001;
      end
    end
  end
endmodule // aefl_cnt

// >>> aefl_top.v
// aefl_top.v: error-flag and motion-lockout logic of the actuator controller.
// assumes a command decoder hands over each received process data object as
// a one-cycle strobe with its fields, and sensor logic gives level and pulse
// indications, all synchronous to clk_in.
// Function
// - parameter flag, bit 0, set on an out-of-range received command value
// - no motion at all while the parameter flag is set
// - overload flag, bit 1, after current above limit for 8 ms of motion
// - after overload, motion only after master clears motion enable
// - voltage flag, bit 2, while supply is outside running range
// - voltage fault: running motion lasts up to 10 s, no new starts
// - temperature flag, bit 3; same 10 s grace and start refusal
// - backdrive flag, bit 4, on uncommanded extension tube movement
// - timeout flag, bit 5, when no command arrives within configured interval
// - timeout interval resets to 5000 ms
// - after timeout, motion only after master clears motion enable
// - fatal flag, bit 6, reported on fatal condition
`timescale 1ns/10ps
`include "aefl_map.vh"
module aefl_top #(
  parameter [63:0] MS_CYC    = `AEFL_CLK_HZ / `AEFL_MS_PER_S,
  parameter [63:0] OVL_CYC   = `AEFL_OVL_MS * (`AEFL_CLK_HZ / `AEFL_MS_PER_S),
  parameter [63:0] GRACE_CYC = `AEFL_GRACE_S * `AEFL_CLK_HZ
) (
  input  wire        clk_in,          // block clock, 250 MHz
  input  wire        rst_in,          // synchronous reset, high
  input  wire        ce_in,           // clock enable, freezes all state
  input  wire [7:0]  addr_in,         // register byte address
  input  wire [31:0] wdata_in,        // register write data
  input  wire        wr_in,           // register write strobe
  input  wire        rd_in,           // register read strobe
  output wire [31:0] rdata_out,       // read data, cycle after rd_in
  input  wire        rpdo_valid_in,   // command object received, pulse
  input  wire        rpdo_enable_in,  // motion enable bit
  input  wire        rpdo_ext_in,     // request extend
  input  wire        rpdo_ret_in,     // request retract
  input  wire [15:0] rpdo_cur_lim_in, // current limit
  input  wire [7:0]  rpdo_speed_in,   // speed setting
  input  wire [15:0] cur_meas_in,     // measured motor current
  input  wire        volt_ok_in,      // supply inside running range
  input  wire        temp_ok_in,      // temperature inside running range
  input  wire        tube_move_in,    // tube position changed, pulse
  input  wire        fatal_in,        // fatal fault detected, pulse
  output wire        drive_ext_out,   // motor drive extend
  output wire        drive_ret_out,   // motor drive retract
  output wire [7:0]  err_flags_out,   // error object
  output wire        irq_out          // interrupt, level
);

  reg  [6:0]  flags_ff;
  reg  [6:0]  nxt_flags;
  reg  [6:0]  flags_prev_ff;
  reg  [6:0]  irq_sts_ff;
  reg  [6:0]  irq_msk_ff;
  reg  [15:0] tmo_ms_ff;
  reg  [15:0] cur_lim_ff;
  reg         enable_ff;
  reg         ext_ff;
  reg         ret_ff;
  reg         moving_ff;
  reg         nxt_moving;
  reg         drv_ext_ff;
  reg         drv_ret_ff;
  reg  [31:0] rdata_ff;
  reg  [31:0] nxt_rdata;
  reg  [19:0] div_ff;
  reg         ms_tick_ff;
  wire        rpdo_bad;
  wire        move_req;
  wire        env_err;
  wire        over_cur;
  wire        ovl_done;
  wire        grace_done;
  wire        tmo_done;
  wire        start_ok;
  wire        hold_ok;
  wire        en_reset;
  wire [6:0]  rise;
  wire        sts_wr;

  assign rpdo_bad = (rpdo_cur_lim_in > `AEFL_MAX_CUR_LIM) ||
                    (rpdo_speed_in > `AEFL_MAX_SPEED);
  // a command with enable low is the master's reset of the overload and timeout lockouts
  assign en_reset = rpdo_valid_in && !rpdo_enable_in;
  assign move_req = enable_ff && (ext_ff ^ ret_ff);
  assign env_err  = !volt_ok_in || !temp_ok_in;
  assign over_cur = moving_ff && (cur_meas_in > cur_lim_ff);

  // latch the last accepted command; enable is always taken so the
  // master can clear lockouts even with an out-of-range object
  always @(posedge clk_in) begin
    if (rst_in) begin
      enable_ff  <= 1'b0;
      ext_ff     <= 1'b0;
      ret_ff     <= 1'b0;
      cur_lim_ff <= `AEFL_RST_CUR_LIM;
    end else if (ce_in && rpdo_valid_in) begin
      enable_ff <= rpdo_enable_in;
      if (!rpdo_bad) begin
        ext_ff     <= rpdo_ext_in;
        ret_ff     <= rpdo_ret_in;
        cur_lim_ff <= rpdo_cur_lim_in;
      end
    end
  end

  // 8 ms overload
  // the count clears on any sample at or below the limit, so the time
  // above the limit must be consecutive
  aefl_cnt u_ovl_cnt (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .clr_in   (!over_cur),
    .step_in  (over_cur),
    .limit_in (OVL_CYC[31:0]),
    .done_out (ovl_done)
  );

  // motion grace
  // counts only while moving under a fault; a stopped actuator starts
  // the window again from zero on its next allowed start
  aefl_cnt u_grace_cnt (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .clr_in   (!(moving_ff && env_err)),
    .step_in  (1'b1),
    .limit_in (GRACE_CYC[31:0]),
    .done_out (grace_done)
  );

  // millisecond tick for the command timeout
  // one free-running prescaler keeps the timeout counter narrow; the cost
  // is that an interval restarted by a command may end up to one tick early
  always @(posedge clk_in) begin
    if (rst_in) begin
      div_ff     <= 20'h00000;
      ms_tick_ff <= 1'b0;
    end else if (ce_in) begin
      ms_tick_ff <= (div_ff == MS_CYC[19:0] - 20'h00001);
      if (div_ff == MS_CYC[19:0] - 20'h00001) begin
        div_ff <= 20'h00000;
      end else begin
        div_ff <= div_ff + 20'h00001;
      end
    end
  end

  // command timeout
  // any object restarts the interval, not only one with motion enable
  aefl_cnt u_tmo_cnt (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .clr_in   (rpdo_valid_in),
    .step_in  (ms_tick_ff),
    .limit_in ({16'h0000, tmo_ms_ff}),
    .done_out (tmo_done)
  );

  assign start_ok = move_req && !flags_ff[`AEFL_BIT_PARAM] &&
                    !flags_ff[`AEFL_BIT_OVL] && !flags_ff[`AEFL_BIT_TMO] &&
                    !flags_ff[`AEFL_BIT_FATAL];
  // running motion survives a supply or temperature fault
  assign hold_ok  = start_ok && !grace_done;

  // motion state: new starts need a healthy supply and temperature,
  // a running motion needs start_ok and the grace window still open
  always @* begin
    nxt_moving = moving_ff;
    if (moving_ff) begin
      nxt_moving = hold_ok;
    end else begin
      nxt_moving = start_ok && !env_err;
    end
    // immediate lockout
    // a locking flag raised at this edge also drops or blocks the drive at this
    // edge, so a locking flag and the drive never show together
    if (nxt_flags[`AEFL_BIT_PARAM] || nxt_flags[`AEFL_BIT_OVL] ||
        nxt_flags[`AEFL_BIT_TMO] || nxt_flags[`AEFL_BIT_FATAL]) begin
      nxt_moving = 1'b0;
    end
  end

  // error flag next state; overload, backdrive and timeout flags drop only on enable reset
  always @* begin
    nxt_flags = flags_ff;
    if (rpdo_valid_in) begin
      nxt_flags[`AEFL_BIT_PARAM] = rpdo_bad;
    end
    if (en_reset) begin
      nxt_flags[`AEFL_BIT_OVL] = 1'b0;
    end
    if (ovl_done) begin
      nxt_flags[`AEFL_BIT_OVL] = 1'b1;
    end
    nxt_flags[`AEFL_BIT_VOLT] = !volt_ok_in;
    nxt_flags[`AEFL_BIT_TEMP] = !temp_ok_in;
    if (en_reset) begin
      nxt_flags[`AEFL_BIT_BKDRV] = 1'b0;
    end
    if (tube_move_in && !moving_ff) begin
      nxt_flags[`AEFL_BIT_BKDRV] = 1'b1;
    end
    if (en_reset) begin
      nxt_flags[`AEFL_BIT_TMO] = 1'b0;
    end
    if (tmo_done && !rpdo_valid_in) begin
      nxt_flags[`AEFL_BIT_TMO] = 1'b1;
    end
    if (fatal_in) begin
      nxt_flags[`AEFL_BIT_FATAL] = 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      flags_ff   <= `AEFL_RST_FLAGS;
      moving_ff  <= 1'b0;
      drv_ext_ff <= 1'b0;
      drv_ret_ff <= 1'b0;
    end else if (ce_in) begin
      flags_ff   <= nxt_flags;
      moving_ff  <= nxt_moving;
      drv_ext_ff <= nxt_moving && ext_ff;
      drv_ret_ff <= nxt_moving && ret_ff;
    end
  end

  // interrupt events are flag rising edges, so a fault that stays up
  // raises one event rather than refilling the status after each clear
  assign rise   = flags_ff & ~flags_prev_ff;
  assign sts_wr = wr_in && (addr_in == `AEFL_OFS_IRQ_STS);

  // status: write one clears, a same-cycle event wins over the clear
  always @(posedge clk_in) begin
    if (rst_in) begin
      flags_prev_ff <= `AEFL_RST_FLAGS;
      irq_sts_ff    <= `AEFL_RST_FLAGS;
      irq_msk_ff    <= `AEFL_RST_MSK;
      tmo_ms_ff     <= `AEFL_RST_TMO_MS;
    end else if (ce_in) begin
      flags_prev_ff <= flags_ff;
      irq_sts_ff    <= (irq_sts_ff & ~(sts_wr ? wdata_in[6:0] : 7'h00))
                       | rise;
      if (wr_in && (addr_in == `AEFL_OFS_IRQ_MSK)) begin
        irq_msk_ff <= wdata_in[6:0];
      end
      if (wr_in && (addr_in == `AEFL_OFS_TMO_MS)) begin
        tmo_ms_ff <= wdata_in[15:0];
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = `AEFL_RST_RDATA;
    case (addr_in)
      `AEFL_OFS_ERR:     nxt_rdata = {25'h0000000, flags_ff};
      `AEFL_OFS_IRQ_STS: nxt_rdata = {25'h0000000, irq_sts_ff};
      `AEFL_OFS_IRQ_MSK: nxt_rdata = {25'h0000000, irq_msk_ff};
      `AEFL_OFS_TMO_MS:  nxt_rdata = {16'h0000, tmo_ms_ff};
      `AEFL_OFS_MOTION:  nxt_rdata = {29'h00000000, moving_ff,
                                      drv_ret_ff, drv_ext_ff};
      default:           nxt_rdata = `AEFL_RST_RDATA;
    endcase
  end

  // read data stands only in the cycle after the strobe
  // zero outside that cycle, so an OR of several slaves stays clean
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_ff <= `AEFL_RST_RDATA;
    end else if (ce_in) begin
      rdata_ff <= rd_in ? nxt_rdata : `AEFL_RST_RDATA;
    end
  end

  assign rdata_out     = rdata_ff;
  assign err_flags_out = {1'b0, flags_ff};
  assign drive_ext_out = drv_ext_ff;
  assign drive_ret_out = drv_ret_ff;
  assign irq_out       = |(irq_sts_ff & irq_msk_ff);
endmodule // aefl_top

// >>> aefl_props.sv
// aefl_props.sv: port assertions for the error-flag block.
// assumes ce_in is low only while the watched inputs stand still.
`timescale 1ns/10ps
`include "aefl_map.vh"
module aefl_chk (
  input wire logic        clk_in,          // clock
  input wire logic        rst_in,          // sync reset
  input wire logic        rpdo_valid_in,   // object strobe
  input wire logic [15:0] rpdo_cur_lim_in, // current limit
  input wire logic [7:0]  rpdo_speed_in,   // speed
  input wire logic        volt_ok_in,      // supply ok
  input wire logic        temp_ok_in,      // temperature ok
  input wire logic        drive_ext_out,   // extend drive
  input wire logic        drive_ret_out,   // retract drive
  input wire logic [7:0]  err_flags_out    // error object
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // any drive at all, used by the lockout checks
  wire mv = drive_ext_out | drive_ret_out;
  top_bit_zero_a: assert property (err_flags_out[7] == 1'b0)
    else $error("bit 7 of error object set");
  param_set_a: assert property (rpdo_valid_in &&
    (rpdo_cur_lim_in > `AEFL_MAX_CUR_LIM || rpdo_speed_in > `AEFL_MAX_SPEED)
    |=> err_flags_out[0]) else $error("range flag not set");
  param_lock_a: assert property (err_flags_out[0] |-> !mv)
    else $error("motion with range flag");
  ovl_lock_a: assert property (err_flags_out[1] |-> !mv)
    else $error("motion with overload flag");
  tmo_lock_a: assert property (err_flags_out[5] |-> !mv)
    else $error("motion with timeout flag");
  volt_flag_a: assert property (!$past(rst_in) |->
    err_flags_out[2] == !$past(volt_ok_in)) else $error("voltage flag");
  temp_flag_a: assert property (!temp_ok_in |=> err_flags_out[3])
    else $error("temperature flag not set");
  start_ok_a: assert property ($rose(drive_ext_out) ||
    $rose(drive_ret_out) |-> $past(volt_ok_in) && $past(temp_ok_in))
    else $error("start in fault");
  fatal_hold_a: assert property (err_flags_out[6] |=>
    err_flags_out[6]) else $error("fatal flag dropped");
endmodule // aefl_chk
bind aefl_top aefl_chk chk_u (.*);

// >>> aefl_master.sv
// aefl_master.sv: command master model issuing one object per send call.
// assumes the bench calls send; fields hold no meaning off the strobe.
`timescale 1ns/10ps
module aefl_master (
  input  wire logic        clk_in,    // clock
  output logic             valid_out, // object strobe
  output logic             en_out,    // motion enable
  output logic             ext_out,   // extend request
  output logic             ret_out,   // retract request
  output logic [15:0]      lim_out,   // current limit
  output logic [7:0]       spd_out    // speed
);
  initial {valid_out, en_out, ext_out, ret_out, lim_out, spd_out} = '0;
  // fields flip after the strobe so the block cannot lean on stale values
  task automatic send(input logic e, x, r, input logic [15:0] l,
                      input logic [7:0] s);
    @(posedge clk_in);
    {valid_out, en_out, ext_out, ret_out, lim_out, spd_out} <=
      {1'b1, e, x, r, l, s};
    @(posedge clk_in);
    {valid_out, en_out, ext_out, ret_out, lim_out, spd_out} <=
      {1'b0, ~e, ~x, ~r, ~l, ~s};
  endtask
endmodule // aefl_master

// >>> aefl_tb.sv
// aefl_tb.sv: directed bench for the error-flag block.
// assumes short timing parameters: 10 cycles per ms, 16, 50.
`timescale 1ns/10ps
`define CHK(g,e,m) begin comparisons++; if ((g)!==(e)) begin \
  n_errors++; $display("CHECK FAILED t=%0t %s",$time,m); end end
module tb;
  logic clk_in = 0, rst_in = 1, ce_in = 1, wr_in = 0, rd_in = 0;
  logic volt_ok_in = 1, temp_ok_in = 1, tube_move_in = 0, fatal_in = 0;
  logic [7:0]  addr_in = 0;
  logic [31:0] wdata_in = 0, v;
  logic [15:0] cur_meas_in = 0, rpdo_cur_lim_in;
  logic [7:0]  rpdo_speed_in, err_flags_out;
  logic [31:0] rdata_out;
  logic rpdo_valid_in, rpdo_enable_in, rpdo_ext_in, rpdo_ret_in;
  logic drive_ext_out, drive_ret_out, irq_out;
  int n_errors = 0, comparisons = 0;
  aefl_top #(.MS_CYC(64'd10), .OVL_CYC(64'd16), .GRACE_CYC(64'd50))
    dut_u (.*);
  aefl_master m_u (.clk_in(clk_in), .valid_out(rpdo_valid_in),
    .en_out(rpdo_enable_in), .ext_out(rpdo_ext_in), .ret_out(rpdo_ret_in),
    .lim_out(rpdo_cur_lim_in), .spd_out(rpdo_speed_in));
  initial forever #2 clk_in = ~clk_in;
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // bounded wait for one error flag; running out ends the run
  task automatic waitf(input int b, input int lim);
    for (int i = 0; i < lim && err_flags_out[b] !== 1'b1; i++) cyc(1);
    if (err_flags_out[b] !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED t=%0t flag wait", $time);
      report_and_stop;
    end
  endtask
  task automatic go(input logic e, input logic [15:0] l, input logic [7:0] s);
    m_u.send(e, 1'b1, 1'b0, l, s);
    cyc(3);
  endtask
  task automatic t_regs;
    rd(8'h00, v); `CHK(v, 32'h0, "flags at reset")
    cyc(1); `CHK(rdata_out, 32'h0, "read data one cycle")
    rd(8'h0C, v); `CHK(v, 32'h1388, "timeout at reset")
    rd(8'h08, v); `CHK(v, 32'h0, "mask at reset")
    // a write while the clock enable is low must be lost
    @(posedge clk_in) ce_in <= 1'b0;
    wr(8'h08, 32'h7F);
    ce_in <= 1'b1;
    rd(8'h08, v); `CHK(v, 32'h0, "write under freeze")
    wr(8'h00, 32'hFF);
    rd(8'h00, v); `CHK(v, 32'h0, "read-only flags")
    rd(8'h20, v); `CHK(v, 32'h0, "unmapped read")
  endtask
  task automatic t_param;
    go(1, 16'h10, 8'h10); `CHK(drive_ext_out, 1'b1, "start")
    go(1, 16'h100, 8'h10);
    `CHK(err_flags_out[0], 1'b1, "bad limit")
    `CHK(drive_ext_out, 1'b0, "motion after bad")
    go(1, 16'h10, 8'h65); `CHK(err_flags_out[0], 1'b1, "bad speed")
    go(1, 16'h00FF, 8'h64);
    `CHK(err_flags_out[0], 1'b0, "edge values")
    go(0, 16'h10, 8'h10); `CHK(drive_ext_out, 1'b0, "stop")
  endtask
  // voltage (b=2) or temperature (b=3) fault during motion
  task automatic t_fault(input int b);
    go(1, 16'h10, 8'h10);
    @(posedge clk_in) {volt_ok_in, temp_ok_in} <= (b == 2) ? 2'b01 : 2'b10;
    waitf(b, 3);
    // the grace window is 50 edges of motion under the fault
    cyc(49); `CHK(drive_ext_out, 1'b1, "grace motion")
    cyc(1); `CHK(drive_ext_out, 1'b0, "grace end")
    go(1, 16'h10, 8'h10);
    `CHK(drive_ext_out, 1'b0, "start in fault")
    go(0, 16'h10, 8'h10);
    @(posedge clk_in) {volt_ok_in, temp_ok_in} <= 2'b11;
    cyc(3); `CHK(err_flags_out[b], 1'b0, "fault gone")
    go(1, 16'h10, 8'h10);
    `CHK(drive_ext_out, 1'b1, "start after fault")
    go(0, 16'h10, 8'h10);
  endtask
  task automatic t_ovl;
    @(posedge clk_in) cur_meas_in <= 16'h20;
    go(1, 16'h10, 8'h10);
    `CHK(err_flags_out[1], 1'b0, "early overload")
    // over-current counts from the first moving edge; 16 samples flag it
    cyc(14); `CHK(err_flags_out[1], 1'b0, "overload one short")
    cyc(1); `CHK(err_flags_out[1], 1'b1, "overload on time")
    waitf(1, 30);
    cyc(2); `CHK(drive_ext_out, 1'b0, "overload stop")
    @(posedge clk_in) cur_meas_in <= 16'h0;
    go(1, 16'h10, 8'h10); `CHK(drive_ext_out, 1'b0, "no re-arm")
    go(0, 16'h10, 8'h10); `CHK(err_flags_out[1], 1'b0, "cleared")
    go(1, 16'h10, 8'h10); `CHK(drive_ext_out, 1'b1, "restart")
    go(0, 16'h10, 8'h10);
  endtask
  task automatic t_tmo;
    wr(8'h08, 32'h20);
    wr(8'h0C, 32'h3);
    waitf(5, 60);
    // the status takes the flag edge one cycle after the flag shows
    cyc(1); `CHK(irq_out, 1'b1, "irq raised")
    wr(8'h04, 32'h20);
    cyc(1); `CHK(irq_out, 1'b0, "irq cleared")
    go(1, 16'h10, 8'h10);
    `CHK(drive_ext_out, 1'b0, "timeout lock")
    wr(8'h0C, 32'h1388);
    go(0, 16'h10, 8'h10);
    `CHK(err_flags_out[5], 1'b0, "timeout clear")
    go(1, 16'h10, 8'h10); `CHK(drive_ext_out, 1'b1, "after reset")
    go(0, 16'h10, 8'h10);
  endtask
  task automatic t_misc;
    m_u.send(1'b1, 1'b0, 1'b1, 16'h10, 8'h10);
    cyc(3); `CHK(drive_ret_out, 1'b1, "retract")
    `CHK(drive_ext_out, 1'b0, "no extend in retract")
    rd(8'h10, v); `CHK(v, 32'h6, "motion register")
    // tube movement during a commanded motion is not backdrive
    @(posedge clk_in) tube_move_in <= 1'b1;
    @(posedge clk_in) tube_move_in <= 1'b0;
    cyc(2); `CHK(err_flags_out[4], 1'b0, "commanded move")
    go(0, 16'h10, 8'h10);
    @(posedge clk_in) tube_move_in <= 1'b1;
    @(posedge clk_in) tube_move_in <= 1'b0;
    waitf(4, 3);
    @(posedge clk_in) fatal_in <= 1'b1;
    @(posedge clk_in) fatal_in <= 1'b0;
    waitf(6, 3);
    go(0, 16'h10, 8'h10);
    `CHK(err_flags_out, 8'h40, "fatal stays")
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    $display("regs done");
    t_param;
    $display("param done");
    t_fault(2);
    t_fault(3);
    $display("fault done");
    t_ovl;
    $display("overload done");
    t_tmo;
    $display("timeout done");
    t_misc;
    $display("misc done");
    report_and_stop;
  end
endmodule // tb
